// >>> pkg/tcr_pkg.sv
/*
  Shared constants and types for the timestamp and transmit-control register slice.
  Assumes an I2C host on the configuration pins and one transmit link clock for both ports.
*/
package tcr_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_P0_HIGH = 8'h2A;
  localparam logic [7:0] ADDR_P0_LOW = 8'h2B;
  localparam logic [7:0] ADDR_P1_HIGH = 8'h2C;
  localparam logic [7:0] ADDR_P1_LOW = 8'h2D;
  localparam logic [7:0] ADDR_P2_HIGH = 8'h2E;
  localparam logic [7:0] ADDR_P2_LOW = 8'h2F;
  localparam logic [7:0] ADDR_P3_HIGH = 8'h30;
  localparam logic [7:0] ADDR_P3_LOW = 8'h31;
  localparam logic [7:0] ADDR_SEL = 8'h32;
  localparam logic [7:0] ADDR_CTL = 8'h33;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] SEL_MASK = 8'h13;
  localparam logic [7:0] CTL_MASK = 8'h7F;
  localparam int SEL_RD_BIT = 4;
  localparam int SEL_WR0_BIT = 0;
  localparam int NUM_RX = 4;
  localparam int NUM_TX = 2;
  localparam int STAMP_W = 16;
  localparam int CFG_W = 7;
  // ----------------------------------------
  // field codes and timing
  // ----------------------------------------
  localparam logic [1:0] LP_DATA = 2'h1;
  localparam logic [1:0] LP_ALL = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [9:0] SKEW_CAL_CYCLES = 10'h3FF;

  typedef struct packed {
    logic [NUM_RX-1:0] load;
    logic [NUM_RX-1:0][STAMP_W-1:0] value;
  } tcr_capture_type;

  // bit order matches the control register bits 6..0
  typedef struct packed {
    logic cal_en;
    logic [1:0] lane_cnt;
    logic [1:0] lp_force;
    logic cont_clk;
    logic enable;
  } tcr_tx_cfg_type;

  typedef struct packed {
    logic [3:0] lane_en;
    logic data_lp00;
    logic clk_lp00;
    logic clk_cont;
    logic skew_cal;
    logic hs_ok;
  } tcr_lane_type;

  typedef enum {TX_OFF, TX_CAL, TX_RUN} tcr_tx_state_type;

  typedef enum {I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_REG, I2C_ACK_REG, I2C_WDATA, I2C_ACK_W,
                I2C_RDATA, I2C_ACK_R} tcr_i2c_state_type;

  // active data lanes: 00 four, 01 three, 10 two, 11 one
  function automatic logic [3:0] lane_mask(input logic [1:0] cnt);
    case (cnt)
      2'h0: lane_mask = 4'hF;
      2'h1: lane_mask = 4'h7;
      2'h2: lane_mask = 4'h3;
      default: lane_mask = 4'h1;
    endcase
  endfunction
endpackage

// >>> logic/tcr_sync.sv
/*
  Two-flop synchroniser for levels, any width.
  Assumes each bit is a slow level; multi-bit values must be quasi-static while they change.
*/
`timescale 1ns/1ns
module tcr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= INIT;
      q_o <= INIT;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // tcr_sync

// >>> logic/tcr_tx_port.sv
/*
  Link-side control of one transmit port: skew calibration, lane enables, forced low-power and clock mode.
  Assumes cfg_i is already synchronised to tx_clk_i and pkt_sent_i comes from logic on tx_clk_i.
*/
`timescale 1ns/1ns
module tcr_tx_port
(
  input wire logic tx_clk_i,
  input wire logic tx_rst_n_i,
  input wire tcr_pkg::tcr_tx_cfg_type cfg_i,
  input wire logic pkt_sent_i,
  output tcr_pkg::tcr_lane_type lane_o
);
  import tcr_pkg::*;

  tcr_tx_state_type state_reg;
  logic [9:0] cal_cnt_reg;
  logic first_pkt_reg;

  always_ff @(posedge tx_clk_i or negedge tx_rst_n_i)
  begin
    if (!tx_rst_n_i)
      state_reg <= TX_OFF;
    else
      case (state_reg)
        TX_OFF: if (cfg_i.enable) state_reg <= cfg_i.cal_en ? TX_CAL : TX_RUN;
        TX_CAL:
        begin
          if (!cfg_i.enable)
            state_reg <= TX_OFF;
          else if (cal_cnt_reg == SKEW_CAL_CYCLES)
            state_reg <= TX_RUN;
        end
        TX_RUN: if (!cfg_i.enable) state_reg <= TX_OFF;
        default: state_reg <= TX_OFF;
      endcase
  end

  always_ff @(posedge tx_clk_i or negedge tx_rst_n_i)
  begin
    if (!tx_rst_n_i)
      cal_cnt_reg <= 10'h000;
    else if (state_reg != TX_CAL)
      cal_cnt_reg <= 10'h000;
    else
      cal_cnt_reg <= cal_cnt_reg + 10'h001;
  end

  always_ff @(posedge tx_clk_i or negedge tx_rst_n_i)
  begin
    if (!tx_rst_n_i)
      first_pkt_reg <= 1'b0;
    else if (state_reg != TX_RUN)
      first_pkt_reg <= 1'b0;
    else if (pkt_sent_i)
      first_pkt_reg <= 1'b1;
  end

  always_ff @(posedge tx_clk_i or negedge tx_rst_n_i)
  begin
    if (!tx_rst_n_i)
      lane_o <= '0;
    else
    begin
      lane_o.lane_en <= cfg_i.enable ? lane_mask(cfg_i.lane_cnt) : 4'h0;
      lane_o.data_lp00 <= state_reg == TX_OFF || cfg_i.lp_force == LP_DATA || cfg_i.lp_force == LP_ALL;
      lane_o.clk_lp00 <= state_reg == TX_OFF || cfg_i.lp_force == LP_ALL;
      lane_o.clk_cont <= state_reg == TX_RUN && cfg_i.cont_clk && first_pkt_reg;
      lane_o.skew_cal <= state_reg == TX_CAL;
      lane_o.hs_ok <= state_reg == TX_RUN && cfg_i.lp_force != LP_DATA && cfg_i.lp_force != LP_ALL;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_cal_no_hs;
    @(posedge tx_clk_i) disable iff (!tx_rst_n_i)
    state_reg == TX_CAL |=> lane_o.skew_cal && !lane_o.hs_ok;
  endproperty
  a_cal_no_hs: assert property (p_cal_no_hs) else $error("hs data during skew calibration");

  property p_lanes;
    @(posedge tx_clk_i) disable iff (!tx_rst_n_i)
    cfg_i.enable && $stable(cfg_i) |=> lane_o.lane_en == lane_mask($past(cfg_i.lane_cnt));
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane enables do not match lane count");

  property p_cont;
    @(posedge tx_clk_i) disable iff (!tx_rst_n_i)
    $rose(lane_o.clk_cont) |-> $past(first_pkt_reg) && $past(cfg_i.cont_clk);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous clock before first packet");

  c_cal_done: cover property (@(posedge tx_clk_i) disable iff (!tx_rst_n_i)
    state_reg == TX_CAL ##1 state_reg == TX_RUN);
endmodule // tcr_tx_port

// >>> logic/tcr_regs.sv
/*
  Timestamp readback and transmit port select/control registers behind an I2C slave.
  Assumes capture logic and the timestamp freeze control run on mclk_i, and the transmit links on tx_clk_i.
*/
`timescale 1ns/1ns
module tcr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h30 // arbitrary bus address
)
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire tcr_pkg::tcr_capture_type capture_i,
  input wire logic stamp_hold_i,
  input wire logic stamps_ready_i,
  output logic stamps_ready_flag_o,
  output logic [3:0] stamp_valid_o,
  input wire logic tx_clk_i,
  input wire logic [1:0] pkt_sent_i,
  output tcr_pkg::tcr_lane_type [1:0] lane_o
);
  import tcr_pkg::*;

  // ----------------------------------------
  // resets
  // ----------------------------------------
  logic [1:0] rst_pipe_reg;
  logic [1:0] tx_rst_pipe_reg;
  logic rst_n;
  logic tx_rst_n;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_pipe_reg <= 2'h0;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  assign rst_n = rst_pipe_reg[1];

  always_ff @(posedge tx_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tx_rst_pipe_reg <= 2'h0;
    else
      tx_rst_pipe_reg <= {tx_rst_pipe_reg[0], 1'b1};
  end
  assign tx_rst_n = tx_rst_pipe_reg[1];

  // ----------------------------------------
  // pin conditioning
  // ----------------------------------------
  logic [1:0] pin_s;
  logic [1:0] pin_d_reg;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  tcr_sync #(.W(2), .INIT(2'h3)) u_pin_sync
  (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .d_i({scl_i, sda_i}),
    .q_o(pin_s)
  );

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      pin_d_reg <= 2'h3;
    else
      pin_d_reg <= pin_s;
  end

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  assign scl_d = pin_d_reg[1];
  assign sda_d = pin_d_reg[0];
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // ----------------------------------------
  // i2c slave engine
  // ----------------------------------------
  tcr_i2c_state_type state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic nack_reg;
  logic sda_low_reg;
  logic [7:0] rd_byte;
  logic wr_pulse;
  logic rd_load;

  assign wr_pulse = scl_fall && state_reg == I2C_WDATA && cnt_reg == BITS_PER_BYTE;
  assign rd_load = scl_fall && ((state_reg == I2C_ACK_ADDR && rw_reg) || (state_reg == I2C_ACK_R && !nack_reg));

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= I2C_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end
    else if (bus_start)
    begin
      state_reg <= I2C_ADDR;
      cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_reg <= I2C_IDLE;
      sda_low_reg <= 1'b0;
    end
    else if (scl_rise)
    begin
      shift_reg <= {shift_reg[6:0], sda_s};
      cnt_reg <= cnt_reg + 4'h1;
      if (state_reg == I2C_ACK_R)
        nack_reg <= sda_s;
    end
    else if (scl_fall)
    begin
      if (rd_load)
      begin
        // first bit goes out now, the rest on later falling edges
        state_reg <= I2C_RDATA;
        cnt_reg <= 4'h0;
        tx_reg <= {rd_byte[6:0], 1'b0};
        sda_low_reg <= !rd_byte[7];
        ptr_reg <= ptr_reg + 8'h01;
      end
      else
        case (state_reg)
          I2C_ADDR:
          begin
            if (cnt_reg == BITS_PER_BYTE)
            begin
              if (shift_reg[7:1] == DEV_ADDR)
              begin
                state_reg <= I2C_ACK_ADDR;
                rw_reg <= shift_reg[0];
                sda_low_reg <= 1'b1;
              end
              else
                state_reg <= I2C_IDLE;
            end
          end
          I2C_ACK_ADDR, I2C_ACK_REG, I2C_ACK_W:
          begin
            state_reg <= (state_reg == I2C_ACK_ADDR) ? I2C_REG : I2C_WDATA;
            cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
          end
          I2C_REG:
          begin
            if (cnt_reg == BITS_PER_BYTE)
            begin
              ptr_reg <= shift_reg;
              state_reg <= I2C_ACK_REG;
              sda_low_reg <= 1'b1;
            end
          end
          I2C_WDATA:
          begin
            if (cnt_reg == BITS_PER_BYTE)
            begin
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= I2C_ACK_W;
              sda_low_reg <= 1'b1;
            end
          end
          I2C_RDATA:
          begin
            if (cnt_reg == BITS_PER_BYTE)
            begin
              state_reg <= I2C_ACK_R;
              sda_low_reg <= 1'b0;
            end
            else
            begin
              sda_low_reg <= !tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
          I2C_ACK_R: state_reg <= I2C_IDLE;
          default: state_reg <= I2C_IDLE;
        endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_reg;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] sel_reg;
  logic [NUM_TX-1:0][7:0] ctl_reg;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      sel_reg <= REG_RESET;
    else if (wr_pulse && ptr_reg == ADDR_SEL)
      sel_reg <= shift_reg & SEL_MASK;
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      ctl_reg <= '0;
    else
      for (int p = 0; p < NUM_TX; p++)
        if (wr_pulse && ptr_reg == ADDR_CTL && sel_reg[SEL_WR0_BIT+p])
          ctl_reg[p] <= shift_reg & CTL_MASK;
  end

  // ----------------------------------------
  // captured timestamps
  // ----------------------------------------
  logic [NUM_RX-1:0][STAMP_W-1:0] stamp_reg;
  logic [NUM_RX-1:0] valid_reg;
  logic ready_reg;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stamp_reg <= '0;
      valid_reg <= 4'h0;
    end
    else
      for (int i = 0; i < NUM_RX; i++)
        if (!stamp_hold_i && capture_i.load[i])
        begin
          stamp_reg[i] <= capture_i.value[i];
          valid_reg[i] <= 1'b1;
        end
  end

  // freeze clears the flag and keeps it clear for as long as it lasts
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      ready_reg <= 1'b0;
    else if (stamp_hold_i)
      ready_reg <= 1'b0;
    else if (stamps_ready_i)
      ready_reg <= 1'b1;
  end

  assign stamps_ready_flag_o = ready_reg;
  assign stamp_valid_o = valid_reg;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb
  begin
    case (ptr_reg)
      ADDR_P0_HIGH: rd_byte = stamp_reg[0][15:8];
      ADDR_P0_LOW: rd_byte = stamp_reg[0][7:0];
      ADDR_P1_HIGH: rd_byte = stamp_reg[1][15:8];
      ADDR_P1_LOW: rd_byte = stamp_reg[1][7:0];
      ADDR_P2_HIGH: rd_byte = stamp_reg[2][15:8];
      ADDR_P2_LOW: rd_byte = stamp_reg[2][7:0];
      ADDR_P3_HIGH: rd_byte = stamp_reg[3][15:8];
      ADDR_P3_LOW: rd_byte = stamp_reg[3][7:0];
      ADDR_SEL: rd_byte = sel_reg;
      ADDR_CTL: rd_byte = ctl_reg[sel_reg[SEL_RD_BIT]];
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // transmit ports
  // ----------------------------------------
  for (genvar p = 0; p < NUM_TX; p++)
  begin : g_tx
    tcr_tx_cfg_type cfg_s;

    // control is quasi-static: change it only with the output disabled
    tcr_sync #(.W(CFG_W), .INIT(7'h00)) u_cfg_sync
    (
      .clk_i(tx_clk_i),
      .rst_n_i(tx_rst_n),
      .d_i(ctl_reg[p][CFG_W-1:0]),
      .q_o(cfg_s)
    );

    tcr_tx_port u_port
    (
      .tx_clk_i(tx_clk_i),
      .tx_rst_n_i(tx_rst_n),
      .cfg_i(cfg_s),
      .pkt_sent_i(pkt_sent_i[p]),
      .lane_o(lane_o[p])
    );
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  logic stamp_addr;
  assign stamp_addr = ptr_reg >= ADDR_P0_HIGH && ptr_reg <= ADDR_P3_LOW;

  property p_stamp_ro;
    wr_pulse && stamp_addr && capture_i.load == 4'h0 |=> $stable(stamp_reg);
  endproperty
  a_stamp_ro: assert property (p_stamp_ro) else $error("write changed a timestamp");

  property p_rsvd_zero;
    (sel_reg & ~SEL_MASK) == 8'h00 && ((ctl_reg[0] | ctl_reg[1]) & ~CTL_MASK) == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_hold_stable;
    stamp_hold_i |=> $stable(stamp_reg) && $stable(valid_reg);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("timestamp moved while frozen");

  property p_hold_ready;
    stamp_hold_i [*2] |-> !stamps_ready_flag_o;
  endproperty
  a_hold_ready: assert property (p_hold_ready) else $error("ready flag set while frozen");

  property p_capture;
    !stamp_hold_i && capture_i.load[0] |=> stamp_valid_o[0] && stamp_reg[0] == $past(capture_i.value[0]);
  endproperty
  a_capture: assert property (p_capture) else $error("port 0 capture lost");

  property p_block0;
    wr_pulse && !sel_reg[0] |=> $stable(ctl_reg[0]);
  endproperty
  a_block0: assert property (p_block0) else $error("port 0 written while disabled");

  property p_block1;
    wr_pulse && !sel_reg[1] |=> $stable(ctl_reg[1]);
  endproperty
  a_block1: assert property (p_block1) else $error("port 1 written while disabled");

  property p_both;
    wr_pulse && ptr_reg == ADDR_CTL && sel_reg[1:0] == 2'h3 |=> ctl_reg[0] == $past(shift_reg & CTL_MASK)
      && ctl_reg[1] == $past(shift_reg & CTL_MASK);
  endproperty
  a_both: assert property (p_both) else $error("dual write missed a port");

  property p_read_sel;
    rd_load && ptr_reg == ADDR_CTL |=> sda_oe_o && ptr_reg == ADDR_CTL + 8'h01
      && tx_reg[7:1] == ($past(sel_reg[SEL_RD_BIT]) ? $past(ctl_reg[1][6:0]) : $past(ctl_reg[0][6:0]));
  endproperty
  a_read_sel: assert property (p_read_sel) else $error("wrong port read back");

  property p_reset;
    $rose(rst_n) |-> sel_reg == 8'h00 && ctl_reg == '0 && !sda_oe_o;
  endproperty
  a_reset: assert property (p_reset) else $error("register not zero after reset");

  c_both_write: cover property (wr_pulse && ptr_reg == ADDR_CTL && sel_reg[1:0] == 2'h3);
  c_read_port1: cover property (rd_load && ptr_reg == ADDR_CTL && sel_reg[SEL_RD_BIT]);
  c_stamp_read: cover property (rd_load && stamp_addr && stamp_hold_i);
endmodule // tcr_regs

// >>> verif/tcr_i2c_host.sv
/*
  I2C host model on the configuration pins, SDA open drain with a pull-up, SCL driven high and low.
  Assumes the bench resolves SDA from both pull-downs; SCL rests high between frames.
  Pin changes are aligned to the falling edge of the system clock given on clk_i.
*/
`timescale 1ns/1ns
module tcr_i2c_host
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // data moves well after the falling edge so it never looks like start or stop
  task automatic bit_io(input logic b, output logic s);
    #30 sda_low_o = !b;
    #70 scl_o = 1'b1;
    #50 s = sda_i;
    #50 scl_o = 1'b0;
  endtask
  task automatic start_cond(input logic again);
    if (again)
    begin
      #30 sda_low_o = 1'b0;
      #70 scl_o = 1'b1;
    end
    #50 sda_low_o = 1'b1;
    #50 scl_o = 1'b0;
  endtask
  task automatic stop_cond();
    #30 sda_low_o = 1'b1;
    #70 scl_o = 1'b1;
    #50 sda_low_o = 1'b0;
    #100;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    @(negedge clk_i);
    start_cond(1'b0);
    put_byte({dev, 1'b0}, a0);
    put_byte(ptr, a1);
    put_byte(d, a2);
    stop_cond();
    ack = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    logic s;
    @(negedge clk_i);
    start_cond(1'b0);
    put_byte({dev, 1'b0}, a);
    put_byte(ptr, a);
    start_cond(1'b1);
    put_byte({dev, 1'b1}, a);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(1'b1, s);
    stop_cond();
  endtask
endmodule // tcr_i2c_host

// >>> verif/tcr_regs_tb.sv
/*
  Self-checking bench for the register slice: host model on the pins, capture and link stimulus.
  Assumes tcr_pkg and tcr_i2c_host are compiled first.
*/
`timescale 1ns/1ns
module tcr_regs_tb;
  import tcr_pkg::*;
  localparam logic [6:0] DEV = 7'h30;
  localparam int LIMIT = 80000;
  localparam logic [15:0] STAMPS [4] = '{16'hA1B2, 16'hC3D4, 16'hE5F6, 16'h0718};
  localparam logic [3:0] LANES [4] = '{4'hF, 4'h7, 4'h3, 4'h1};
  logic mclk_i = 1'b0;
  logic tx_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_o;
  logic sda_oe_o;
  logic sda;
  tcr_capture_type capture_i = '0;
  logic stamp_hold_i = 1'b0;
  logic stamps_ready_i = 1'b0;
  logic stamps_ready_flag_o;
  logic [3:0] stamp_valid_o;
  logic [1:0] pkt_sent_i = 2'h0;
  tcr_lane_type [1:0] lane_o;
  tcr_lane_type exp;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  assign sda = !(sda_low | (sda_oe_o & !sda_o));
  always #5 mclk_i = ~mclk_i;
  always #32 tx_clk_i = ~tx_clk_i;
  tcr_regs #(.DEV_ADDR(DEV)) i_dut
  (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .capture_i(capture_i),
    .stamp_hold_i(stamp_hold_i),
    .stamps_ready_i(stamps_ready_i),
    .stamps_ready_flag_o(stamps_ready_flag_o),
    .stamp_valid_o(stamp_valid_o),
    .tx_clk_i(tx_clk_i),
    .pkt_sent_i(pkt_sent_i),
    .lane_o(lane_o)
  );
  tcr_i2c_host i_host
  (
    .clk_i(mclk_i),
    .sda_i(sda),
    .scl_o(scl),
    .sda_low_o(sda_low)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    checked++;
    if (seen !== expv)
    begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic ack;
    i_host.write_reg(DEV, ptr, d, ack);
    check(ack, 1'b1); // every byte acknowledged
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [7:0] expv);
    logic [7:0] d;
    i_host.read_reg(DEV, ptr, d);
    check(d, expv); // readback
  endtask
  task automatic rd_stamp(input int p);
    rd(8'(8'h2A + 2 * p), STAMPS[p][15:8]);
    rd(8'(8'h2B + 2 * p), STAMPS[p][7:0]);
  endtask
  task automatic mwait(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic tx_wait(input int n);
    repeat (n) @(posedge tx_clk_i);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int a = 8'h2A; a <= 8'h34; a++)
      rd(8'(a), 8'h00);
    check(stamp_valid_o, 4'h0);
    check(stamps_ready_flag_o, 1'b0);
    check(lane_o[0], 9'h018);
    check(lane_o[1], 9'h018);
  endtask
  task automatic t_capture();
    @(posedge mclk_i);
    for (int p = 0; p < NUM_RX; p++)
      capture_i.value[p] <= STAMPS[p];
    capture_i.load <= 4'hF;
    @(posedge mclk_i);
    capture_i.load <= 4'h0;
    mwait(2);
    check(stamp_valid_o, 4'hF);
    rd_stamp(0);
    rd_stamp(1);
    rd_stamp(2);
    rd_stamp(3);
    wr(8'h2A, 8'hFF);
    rd(8'h2A, STAMPS[0][15:8]);
  endtask
  task automatic t_freeze();
    @(posedge mclk_i);
    stamps_ready_i <= 1'b1;
    @(posedge mclk_i);
    stamps_ready_i <= 1'b0;
    mwait(2);
    check(stamps_ready_flag_o, 1'b1);
    stamp_hold_i <= 1'b1;
    capture_i.value[0] <= 16'h0000;
    capture_i.load <= 4'h1;
    stamps_ready_i <= 1'b1;
    @(posedge mclk_i);
    capture_i.load <= 4'h0;
    stamps_ready_i <= 1'b0;
    mwait(2);
    check(stamps_ready_flag_o, 1'b0);
    rd_stamp(0);
    @(posedge mclk_i);
    stamp_hold_i <= 1'b0;
  endtask
  task automatic t_select();
    logic ack;
    wr(8'h32, 8'hFF);
    rd(8'h32, 8'h13);
    i_host.write_reg(7'h31, 8'h32, 8'h00, ack);
    check(ack, 1'b0); // foreign address refused
    rd(8'h32, 8'h13);
    wr(8'h32, 8'h10);
    wr(8'h33, 8'h24);
    rd(8'h33, 8'h00);
    wr(8'h32, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h32, 8'h01);
    wr(8'h33, 8'h24);
    rd(8'h33, 8'h24);
    wr(8'h32, 8'h12);
    rd(8'h33, 8'h00);
    wr(8'h33, 8'h08);
    rd(8'h33, 8'h08);
    wr(8'h32, 8'h00);
    rd(8'h33, 8'h24);
    wr(8'h32, 8'h03);
    wr(8'h33, 8'hA0);
    rd(8'h33, 8'h20);
    wr(8'h32, 8'h13);
    rd(8'h33, 8'h20);
  endtask
  task automatic t_lanes();
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h33, 8'h00);
      wr(8'h33, {2'h0, i[1:0], i[1:0], 2'h1});
      tx_wait(8);
      exp = '0;
      exp.lane_en = LANES[i];
      exp.data_lp00 = i[0];
      exp.clk_lp00 = (i == 3);
      exp.hs_ok = !i[0];
      check(lane_o[0], exp);
    end
    wr(8'h33, 8'h00);
    tx_wait(8);
    check(lane_o[0], 9'h018);
  endtask
  task automatic t_cal();
    wr(8'h33, 8'h43);
    tx_wait(8);
    exp = '0;
    exp.lane_en = 4'hF;
    exp.skew_cal = 1'b1;
    check(lane_o[0], exp);
    check(lane_o[1], exp);
    tx_wait(1000);
    check(lane_o[0].skew_cal, 1'b1);
    tx_wait(40);
    exp.skew_cal = 1'b0;
    exp.hs_ok = 1'b1;
    check(lane_o[0], exp);
    @(posedge tx_clk_i);
    pkt_sent_i <= 2'h1;
    @(posedge tx_clk_i);
    pkt_sent_i <= 2'h0;
    tx_wait(3);
    exp.clk_cont = 1'b1;
    check(lane_o[0], exp);
    check(lane_o[1].clk_cont, 1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    mwait(5);
    tx_wait(4);
    t_reset();
    t_capture();
    t_freeze();
    t_select();
    t_lanes();
    t_cal();
    test_done();
  end
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      failures++;
      test_done();
    end
  end
endmodule // tcr_regs_tb
